// File: hw/rvf_core.sv
// Reset sequencing, initial vector fetch and exception vector addressing
//
// The Wishbone register port and the address map are this design's own decisions.
`timescale 1ns/1ps

// What this block does
// - Level requests map pairwise onto auto-vectors 64-71
// - Active-low level code 1110 means level 1
// - Peripheral vectors come from programmable registers 0-255
// - Reset vector address is vector number times four
// - Other vectors add base to number times four
// - Reset overrides every pending or active exception
// - Init low, nmi high gives power-on reset
// - Init low, nmi low gives manual reset
// - Manual reset spares bus, break, ratio registers
// - Power-on handling starts on init rising edge
// - Manual handling starts on init rising edge
// - Fetch PC then SP, then run
// - Clear vector base, set level mask ones
// - Manual reset runs the same fetch steps
// - Manual reset waits for running bus cycle
// - Refresh keeps running through manual reset
// - Vectors at 0x0/0x4 power-on, 0x8/0xC manual

module rvf_core (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic chip_init_pin_n_i,
    input wire logic nmi_pin_i,
    input wire logic [3:0] ext_level_lines_i,
    input wire logic bus_busy_i,
    output rvf_pkg::rvf_fetch_t fetch_o,
    input wire logic fetch_ack_i,
    input wire logic [31:0] fetch_data_i,
    input wire logic exc_req_i,
    input wire rvf_pkg::rvf_src_t exc_src_i,
    input wire logic [7:0] exc_vec_i,
    input wire logic [7:0] ext_vec_i,
    input wire logic [1:0] periph_sel_i,
    output logic [31:0] exc_addr_o,
    output logic exc_addr_valid_o,
    output logic [31:0] pc_o,
    output logic [31:0] sp_o,
    output logic [31:0] vector_table_base_o,
    output logic [3:0] level_mask_bits_o,
    output logic [3:0] level_o,
    output logic cpu_reset_o,
    output logic cpu_run_o,
    output logic periph_reset_o,
    output logic kept_reset_o,
    output logic refresh_en_o
);

    // ****************************************
    // Register decode helpers
    // ****************************************
    localparam logic [3:0] SEL_NONE = 4'hF;

    function automatic logic [3:0] reg_sel(input logic [7:0] adr);
        logic [3:0] s;
        s = SEL_NONE;
        if (adr == rvf_pkg::RVF_CTRL_OFS) begin
            s = 4'h0;
        end else if (adr == rvf_pkg::RVF_STAT_OFS) begin
            s = 4'h1;
        end else if (adr == rvf_pkg::RVF_BASE_OFS) begin
            s = 4'h2;
        end else if (adr == rvf_pkg::RVF_MASK_OFS) begin
            s = 4'h3;
        end else if (adr == rvf_pkg::RVF_LEVEL_OFS) begin
            s = 4'h4;
        end else if (adr[7:4] == rvf_pkg::RVF_PVEC_OFS[7:4] && adr[1:0] == 2'h0
                     && 32'(adr[3:2]) < rvf_pkg::RVF_NPV) begin
            s = {2'h2, adr[3:2]};
        end
        return s;
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wr,
                                          input logic [3:0] sel);
        logic [31:0] m;
        m = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                m[i*8 +: 8] = wr[i*8 +: 8];
            end
        end
        return m;
    endfunction

    // ****************************************
    // State and address formers
    // ****************************************
    rvf_pkg::rvf_state_t r;
    rvf_pkg::rvf_state_t n;

    logic [7:0] rst_vec;
    logic [31:0] rst_addr;
    logic [7:0] exc_vec;
    logic [31:0] exc_addr;
    logic [3:0] dec_level;
    logic [7:0] auto_vec;
    logic [3:0] wsel;
    logic [3:0] rsel;
    logic [31:0] rd_val;
    logic [31:0] wr_word;
    logic wr_go;
    logic rst_seen;

    // Entry 0/1 for power-on, 2/3 for manual; odd entry while the PC fetch is pending
    assign rst_vec = (r.kind_manual ? rvf_pkg::RVF_VEC_MAN_PC : rvf_pkg::RVF_VEC_PON_PC)
                     | {7'h0, r.st == rvf_pkg::RVF_FETCH_PC};

    rvf_vec_map u_rst_map (
        .is_reset_i(1'b1),
        .base_i(r.base),
        .vec_i(rst_vec),
        .lines_i(r.lvl_s2),
        .addr_o(rst_addr),
        .level_o(),
        .auto_vec_o()
    );

    rvf_vec_map u_exc_map (
        .is_reset_i(1'b0),
        .base_i(r.base),
        .vec_i(exc_vec),
        .lines_i(r.lvl_s2),
        .addr_o(exc_addr),
        .level_o(dec_level),
        .auto_vec_o(auto_vec)
    );

    always_comb begin
        unique case (exc_src_i)
            rvf_pkg::RVF_SRC_LEVEL: begin
                // External vector number replaces the auto-vector when enabled
                exc_vec = r.ext_vec_en ? ext_vec_i : auto_vec;
            end
            rvf_pkg::RVF_SRC_PERIPH: begin
                exc_vec = r.pvec[periph_sel_i];
            end
            default: begin
                exc_vec = exc_vec_i;
            end
        endcase
    end

    // ****************************************
    // Wishbone read mux
    // ****************************************
    assign rsel = reg_sel(wb_adr_i);
    assign wsel = rsel;
    assign wr_go = wb_cyc_i & wb_stb_i & wb_we_i & r.ack;

    always_comb begin
        rd_val = 32'h0000_0000;
        unique case (rsel)
            4'h0: rd_val[rvf_pkg::RVF_CTRL_EXTVEC_BIT] = r.ext_vec_en;
            4'h1: begin
                rd_val[rvf_pkg::RVF_STAT_SHORT_BIT] = r.hold_short;
                rd_val[rvf_pkg::RVF_STAT_MANUAL_BIT] = r.kind_manual;
                rd_val[rvf_pkg::RVF_STAT_RUN_BIT] = cpu_run_o;
                rd_val[rvf_pkg::RVF_STAT_CPURST_BIT] = cpu_reset_o;
            end
            4'h2: rd_val = r.base;
            4'h3: rd_val[3:0] = r.mask;
            4'h4: begin
                rd_val[3:0] = r.level;
                rd_val[rvf_pkg::RVF_LEVEL_AUTO_POS +: 8] = auto_vec;
            end
            4'h8, 4'h9, 4'hA, 4'hB: rd_val[7:0] = r.pvec[rsel[1:0]];
            default: rd_val = 32'h0000_0000;
        endcase
    end

    // Reset wins over whatever else is going on
    assign rst_seen = ~r.init_s2 && r.st != rvf_pkg::RVF_HOLD
                      && r.st != rvf_pkg::RVF_BUS_WAIT;

    // ****************************************
    // Next-state logic
    // ****************************************
    always_comb begin
        n = r;
        wr_word = 32'h0000_0000;
        n.init_s1 = chip_init_pin_n_i;
        n.init_s2 = r.init_s1;
        n.nmi_s1 = nmi_pin_i;
        n.nmi_s2 = r.nmi_s1;
        n.lvl_s1 = ext_level_lines_i;
        n.lvl_s2 = r.lvl_s1;
        n.level = dec_level;
        n.ack = wb_cyc_i & wb_stb_i & ~r.ack;
        n.exc_valid = 1'b0;
        if (n.ack) begin
            n.rdata = rd_val;
        end

        // Software writes commit on the edge that sees ack high
        if (wr_go) begin
            unique case (wsel)
                4'h0: begin
                    if (wb_sel_i[0]) begin
                        n.ext_vec_en = wb_dat_i[rvf_pkg::RVF_CTRL_EXTVEC_BIT];
                    end
                end
                4'h1: begin
                    if (wb_sel_i[0] && wb_dat_i[rvf_pkg::RVF_STAT_SHORT_BIT]) begin
                        n.hold_short = 1'b0;
                    end
                end
                4'h2: n.base = merge(r.base, wb_dat_i, wb_sel_i);
                4'h3: begin
                    wr_word = merge({28'h0, r.mask}, wb_dat_i, wb_sel_i);
                    n.mask = wr_word[3:0];
                end
                4'h8, 4'h9, 4'hA, 4'hB: begin
                    if (wb_sel_i[0]) begin
                        n.pvec[wsel[1:0]] = wb_dat_i[7:0];
                    end
                end
                default: ;
            endcase
        end

        if (rst_seen) begin
            // Reset kind follows the nmi level seen as init falls
            n.kind_manual = ~r.nmi_s2;
            n.fetch.req = 1'b0;
            // The edge that first sees init low is already one held cycle
            n.hold_cnt = 5'h01;
            n.st = rvf_pkg::RVF_HOLD;
            // A manual reset never cuts a bus cycle short
            if (~r.nmi_s2 && (bus_busy_i || (r.fetch.req && !fetch_ack_i))) begin
                n.fetch.req = r.fetch.req;
                n.st = rvf_pkg::RVF_BUS_WAIT;
            end
        end else begin
            unique case (r.st)
                rvf_pkg::RVF_BUS_WAIT: begin
                    if (r.fetch.req && fetch_ack_i) begin
                        n.fetch.req = 1'b0;
                    end
                    if (!bus_busy_i && !(r.fetch.req && !fetch_ack_i)) begin
                        n.st = rvf_pkg::RVF_HOLD;
                    end
                end
                rvf_pkg::RVF_HOLD: begin
                    // Peripheral registers sit at their initial values
                    n.ext_vec_en = 1'b0;
                    n.pvec = '0;
                    if (!r.init_s2) begin
                        if (r.hold_cnt != rvf_pkg::RVF_HOLD_MIN) begin
                            n.hold_cnt = r.hold_cnt + 5'h01;
                        end
                    end else begin
                        // Flag a hold shorter than the minimum; set beats clear
                        if (r.hold_cnt < rvf_pkg::RVF_HOLD_MIN) begin
                            n.hold_short = 1'b1;
                        end
                        // Rising init starts handling for both kinds
                        n.base = rvf_pkg::RVF_BASE_RST;
                        n.mask = rvf_pkg::RVF_MASK_RST;
                        n.fetch.req = 1'b1;
                        n.fetch.addr = rst_addr;
                        n.st = rvf_pkg::RVF_FETCH_PC;
                    end
                end
                rvf_pkg::RVF_FETCH_PC: begin
                    if (fetch_ack_i) begin
                        n.pc = fetch_data_i;
                        n.fetch.addr = rst_addr;
                        n.st = rvf_pkg::RVF_FETCH_SP;
                    end
                end
                rvf_pkg::RVF_FETCH_SP: begin
                    if (fetch_ack_i) begin
                        n.sp = fetch_data_i;
                        n.fetch.req = 1'b0;
                        n.st = rvf_pkg::RVF_RUN;
                    end
                end
                rvf_pkg::RVF_RUN: begin
                    if (exc_req_i) begin
                        n.exc_addr = exc_addr;
                        n.exc_valid = 1'b1;
                    end
                end
                default: n.st = rvf_pkg::RVF_HOLD;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= rvf_pkg::RVF_STATE_RST;
        end else begin
            r <= n;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign wb_ack_o = r.ack;
    assign wb_dat_o = r.rdata;
    assign fetch_o = r.fetch;
    assign exc_addr_o = r.exc_addr;
    assign exc_addr_valid_o = r.exc_valid;
    assign pc_o = r.pc;
    assign sp_o = r.sp;
    assign vector_table_base_o = r.base;
    assign level_mask_bits_o = r.mask;
    assign level_o = r.level;
    assign cpu_run_o = r.st == rvf_pkg::RVF_RUN;
    // The core is not held in reset while a manual reset waits for its bus cycle, though run drops
    assign cpu_reset_o = r.st == rvf_pkg::RVF_HOLD || r.st == rvf_pkg::RVF_FETCH_PC
                         || r.st == rvf_pkg::RVF_FETCH_SP;
    assign periph_reset_o = r.st == rvf_pkg::RVF_HOLD;
    // Bus controller, break unit and ratio register reset on power-on only
    assign kept_reset_o = r.st == rvf_pkg::RVF_HOLD && !r.kind_manual;
    // Refresh lives in the bus controller, so it stops only with it
    assign refresh_en_o = !kept_reset_o;

endmodule

// File: hw/rvf_pkg.sv
// Package: register map, constants and types of the reset and vector fetch block
package rvf_pkg;

    // ****************************************
    // Register byte offsets on Wishbone
    // ****************************************
    localparam logic [7:0] RVF_CTRL_OFS = 8'h00;
    localparam logic [7:0] RVF_STAT_OFS = 8'h04;
    localparam logic [7:0] RVF_BASE_OFS = 8'h08;
    localparam logic [7:0] RVF_MASK_OFS = 8'h0C;
    localparam logic [7:0] RVF_LEVEL_OFS = 8'h10;
    localparam logic [7:0] RVF_PVEC_OFS = 8'h20;
    localparam int unsigned RVF_NPV = 4;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int unsigned RVF_CTRL_EXTVEC_BIT = 0;
    localparam int unsigned RVF_STAT_SHORT_BIT = 0;
    localparam int unsigned RVF_STAT_MANUAL_BIT = 1;
    localparam int unsigned RVF_STAT_RUN_BIT = 2;
    localparam int unsigned RVF_STAT_CPURST_BIT = 3;
    localparam int unsigned RVF_LEVEL_AUTO_POS = 8;

    // ****************************************
    // Reset values, vector numbers, timing
    // ****************************************
    localparam logic [31:0] RVF_BASE_RST = 32'h0000_0000;
    localparam logic [3:0] RVF_MASK_RST = 4'hF;
    localparam logic [7:0] RVF_VEC_PON_PC = 8'h00;
    localparam logic [7:0] RVF_VEC_MAN_PC = 8'h02;
    localparam logic [7:0] RVF_AUTO_VEC_BASE = 8'h40;
    localparam logic [4:0] RVF_HOLD_MIN = 5'h14;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [2:0] {
        RVF_HOLD,
        RVF_BUS_WAIT,
        RVF_FETCH_PC,
        RVF_FETCH_SP,
        RVF_RUN
    } rvf_st_t;

    typedef enum logic [1:0] {
        RVF_SRC_VEC,
        RVF_SRC_LEVEL,
        RVF_SRC_PERIPH
    } rvf_src_t;

    typedef struct packed {
        logic req;
        logic [31:0] addr;
    } rvf_fetch_t;

    typedef struct packed {
        logic init_s1;
        logic init_s2;
        logic nmi_s1;
        logic nmi_s2;
        logic [3:0] lvl_s1;
        logic [3:0] lvl_s2;
        rvf_st_t st;
        logic kind_manual;
        logic [4:0] hold_cnt;
        logic hold_short;
        logic [31:0] base;
        logic [3:0] mask;
        logic [31:0] pc;
        logic [31:0] sp;
        logic ext_vec_en;
        logic [RVF_NPV-1:0][7:0] pvec;
        logic [3:0] level;
        logic ack;
        logic [31:0] rdata;
        rvf_fetch_t fetch;
        logic [31:0] exc_addr;
        logic exc_valid;
    } rvf_state_t;

    localparam rvf_state_t RVF_STATE_RST = '{
        st: RVF_HOLD,
        hold_cnt: RVF_HOLD_MIN,
        mask: RVF_MASK_RST,
        base: RVF_BASE_RST,
        default: '0
    };

endpackage

// File: hw/rvf_vec_map.sv
// Vector table address former and external level decoder
`timescale 1ns/1ps

module rvf_vec_map (
    input wire logic is_reset_i,
    input wire logic [31:0] base_i,
    input wire logic [7:0] vec_i,
    input wire logic [3:0] lines_i,
    output logic [31:0] addr_o,
    output logic [3:0] level_o,
    output logic [7:0] auto_vec_o
);

    logic [31:0] offset;

    always_comb begin
        // Longword aligned entry, vector number times four
        offset = {22'h0, vec_i, 2'h0};
        // Reset entries ignore the base all others add it
        addr_o = is_reset_i ? offset : base_i + offset;
        // Lines are active low: 1110 reads as level 1
        level_o = ~lines_i;
        // Levels pair up onto auto-vectors 64..71
        auto_vec_o = rvf_pkg::RVF_AUTO_VEC_BASE + {5'h0, level_o[3:1]};
    end

endmodule

// File: verif/rvf_mem_model.sv
// Vector table memory model answering the core's longword fetches
`timescale 1ns/1ps

module rvf_mem_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic slow_i,
    input wire rvf_pkg::rvf_fetch_t fetch_i,
    output logic fetch_ack_o,
    output logic [31:0] fetch_data_o
);
    logic [2:0] wait_r;

    // ****************************************
    // Longword read with optional wait states
    // ****************************************
    always_ff @(posedge clk_i) begin
        fetch_ack_o <= 1'b0;
        // Data is only valid with ack; otherwise it toggles so stale data is never trusted
        fetch_data_o <= ~fetch_data_o;
        if (rst_i) begin
            wait_r <= 3'h0;
            fetch_data_o <= 32'h0000_0000;
        end else if (fetch_i.req && !fetch_ack_o) begin
            if (wait_r == (slow_i ? 3'h5 : 3'h0)) begin
                fetch_ack_o <= 1'b1;
                fetch_data_o <= 32'hA500_0000 | {fetch_i.addr[31:2], 2'h0};
                wait_r <= 3'h0;
            end else begin
                wait_r <= wait_r + 3'h1;
            end
        end
    end
endmodule

// File: verif/rvf_core_assertions.sv
// Concurrent checks on the reset and vector fetch core ports
`timescale 1ns/1ps

module rvf_core_assertions (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic chip_init_pin_n_i,
    input wire logic nmi_pin_i,
    input wire logic [3:0] ext_level_lines_i,
    input wire logic bus_busy_i,
    input wire rvf_pkg::rvf_fetch_t fetch_o,
    input wire logic fetch_ack_i,
    input wire logic exc_req_i,
    input wire logic exc_addr_valid_o,
    input wire logic [31:0] vector_table_base_o,
    input wire logic [3:0] level_mask_bits_o,
    input wire logic [3:0] level_o,
    input wire logic cpu_reset_o,
    input wire logic cpu_run_o,
    input wire logic periph_reset_o,
    input wire logic kept_reset_o,
    input wire logic refresh_en_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // ****************************************
    // Reset entry
    // ****************************************
    pon_reset_a: assert property ((!chip_init_pin_n_i && nmi_pin_i) [*5] |->
        cpu_reset_o && periph_reset_o && kept_reset_o && !refresh_en_o)
        else $error("power-on reset state not entered");
    man_reset_a: assert property ((!chip_init_pin_n_i && !nmi_pin_i && !bus_busy_i) [*8] |->
        periph_reset_o && !kept_reset_o && refresh_en_o)
        else $error("manual reset state wrong");
    bus_wait_a: assert property ((!nmi_pin_i) [*4] ##0 (bus_busy_i && !periph_reset_o) |=>
        !periph_reset_o)
        else $error("manual reset cut a bus cycle");

    // ****************************************
    // Initial fetch
    // ****************************************
    fetch_start_a: assert property ($rose(fetch_o.req) |->
        fetch_o.addr == (nmi_pin_i ? 32'h0000_0000 : 32'h0000_0008) &&
        level_mask_bits_o == 4'hF && vector_table_base_o == 32'h0000_0000)
        else $error("fetch start address or init wrong");
    fetch_next_a: assert property (fetch_o.req && fetch_ack_i && !fetch_o.addr[2] &&
        chip_init_pin_n_i |=> fetch_o.req && fetch_o.addr == $past(fetch_o.addr) + 32'h4)
        else $error("second fetch word not requested");
    run_start_a: assert property ($rose(cpu_run_o) |->
        $past(fetch_ack_i && fetch_o.req && fetch_o.addr[2]))
        else $error("run began before stack pointer fetch");

    // ****************************************
    // Exceptions and levels
    // ****************************************
    exc_answer_a: assert property (exc_req_i && cpu_run_o && chip_init_pin_n_i |=>
        exc_addr_valid_o ##1 !exc_addr_valid_o)
        else $error("exception address pulse wrong");
    no_exc_reset_a: assert property (cpu_reset_o && $past(cpu_reset_o) |->
        !exc_addr_valid_o)
        else $error("exception served during reset");
    level_dec_a: assert property ((ext_level_lines_i == 4'hE) [*4] |-> level_o == 4'h1)
        else $error("level code not decoded");

    cover property ($rose(cpu_run_o));
    cover property (exc_addr_valid_o);
    cover property ($rose(periph_reset_o) && !kept_reset_o);
endmodule

bind rvf_core rvf_core_assertions u_chk (.clk_i, .rst_i, .chip_init_pin_n_i, .nmi_pin_i,
    .ext_level_lines_i, .bus_busy_i, .fetch_o, .fetch_ack_i, .exc_req_i, .exc_addr_valid_o,
    .vector_table_base_o, .level_mask_bits_o, .level_o, .cpu_reset_o, .cpu_run_o,
    .periph_reset_o, .kept_reset_o, .refresh_en_o);

// File: verif/tb_rvf_core.sv
// Self-checking bench for the reset and vector fetch core
`timescale 1ns/1ps

module tb_rvf_core;
    typedef struct packed {
        logic ctrl;
        rvf_pkg::rvf_src_t src;
        logic [7:0] vec;
        logic [1:0] psel;
        logic [3:0] lines;
        logic [31:0] exp;
    } rvf_row_t;

    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, chip_init_pin_n_i, nmi_pin_i;
    logic bus_busy_i, fetch_ack_i, exc_req_i, exc_addr_valid_o, cpu_reset_o, cpu_run_o;
    logic periph_reset_o, kept_reset_o, refresh_en_o, slow;
    logic [7:0] wb_adr_i, evec;
    logic [31:0] wb_dat_i, wb_dat_o, fetch_data_i, exc_addr_o, pc_o, sp_o, vector_table_base_o;
    logic [31:0] rdat;
    logic [3:0] ext_level_lines_i, level_mask_bits_o, level_o;
    logic [1:0] periph_sel_i;
    rvf_pkg::rvf_src_t exc_src_i;
    rvf_pkg::rvf_fetch_t fetch_o;
    int n_errors = 0;
    int n_checks = 0;
    rvf_row_t rows [9];

    rvf_core uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hF),
        .wb_dat_i, .wb_dat_o, .wb_ack_o, .chip_init_pin_n_i, .nmi_pin_i, .ext_level_lines_i,
        .bus_busy_i, .fetch_o, .fetch_ack_i, .fetch_data_i, .exc_req_i, .exc_src_i,
        .exc_vec_i(evec), .ext_vec_i(evec), .periph_sel_i, .exc_addr_o, .exc_addr_valid_o,
        .pc_o, .sp_o, .vector_table_base_o, .level_mask_bits_o, .level_o, .cpu_reset_o,
        .cpu_run_o, .periph_reset_o, .kept_reset_o, .refresh_en_o);
    rvf_mem_model u_mem (.clk_i, .rst_i, .slow_i(slow), .fetch_i(fetch_o),
        .fetch_ack_o(fetch_ack_i), .fetch_data_o(fetch_data_i));

    // ****************************************
    // Clock, watchdog, shared tasks
    // ****************************************
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end

    initial begin
        repeat (20000) @(posedge clk_i);
        n_errors++;
        test_done();
    end

    task automatic test_done;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Holds the request until ack is sampled; a missing ack ends via the watchdog
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wait_run;
        do @(posedge clk_i); while (cpu_run_o !== 1'b1);
    endtask

    // Drives a reset pin pulse of the given length, then waits for the fetch to finish
    task automatic pin_reset(input logic kind_nmi, input int len);
        nmi_pin_i <= kind_nmi;
        chip_init_pin_n_i <= 1'b0;
        repeat (len) @(posedge clk_i);
        chip_init_pin_n_i <= 1'b1;
        wait_run();
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        rst_i = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, bus_busy_i, exc_req_i, slow} = '0;
        {wb_adr_i, wb_dat_i, evec, periph_sel_i} = '0;
        {chip_init_pin_n_i, nmi_pin_i} = 2'b11;
        ext_level_lines_i = 4'hF;
        exc_src_i = rvf_pkg::RVF_SRC_VEC;
        rows = '{'{1'b0, rvf_pkg::RVF_SRC_VEC, 8'h04, 2'h0, 4'hF, 32'h0000_1010},
            '{1'b0, rvf_pkg::RVF_SRC_VEC, 8'hFF, 2'h0, 4'hF, 32'h0000_13FC},
            '{1'b0, rvf_pkg::RVF_SRC_LEVEL, 8'h00, 2'h0, 4'hE, 32'h0000_1100},
            '{1'b0, rvf_pkg::RVF_SRC_LEVEL, 8'h00, 2'h0, 4'hD, 32'h0000_1104},
            '{1'b0, rvf_pkg::RVF_SRC_LEVEL, 8'h00, 2'h0, 4'h1, 32'h0000_111C},
            '{1'b0, rvf_pkg::RVF_SRC_LEVEL, 8'h00, 2'h0, 4'h0, 32'h0000_111C},
            '{1'b0, rvf_pkg::RVF_SRC_PERIPH, 8'h00, 2'h3, 4'hF, 32'h0000_13FC},
            '{1'b0, rvf_pkg::RVF_SRC_PERIPH, 8'h00, 2'h2, 4'hF, 32'h0000_12A8},
            '{1'b1, rvf_pkg::RVF_SRC_LEVEL, 8'h90, 2'h0, 4'hE, 32'h0000_1240}};
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        wait_run();
        chk(pc_o, 32'hA500_0000);
        chk(sp_o, 32'hA500_0004);
        chk({28'h0, level_mask_bits_o}, 32'h0000_000F);
        wb(1'b1, rvf_pkg::RVF_BASE_OFS, 32'h0000_1000);
        for (int i = 0; i < 4; i++) begin
            wb(1'b1, rvf_pkg::RVF_PVEC_OFS + 8'(4 * i), 32'(85 * i));
        end
        wb(1'b0, rvf_pkg::RVF_BASE_OFS, 32'h0);
        chk(rdat, 32'h0000_1000);
        wb(1'b0, 8'h40, 32'h0);
        chk(rdat, 32'h0000_0000);
        foreach (rows[i]) begin
            wb(1'b1, rvf_pkg::RVF_CTRL_OFS, {31'h0, rows[i].ctrl});
            ext_level_lines_i <= rows[i].lines;
            exc_src_i <= rows[i].src;
            evec <= rows[i].vec;
            periph_sel_i <= rows[i].psel;
            repeat (4) @(posedge clk_i);
            chk({28'h0, level_o}, {28'h0, ~rows[i].lines});
            exc_req_i <= 1'b1;
            @(posedge clk_i);
            exc_req_i <= 1'b0;
            @(posedge clk_i);
            chk(exc_addr_valid_o ? exc_addr_o : 32'hFFFF_FFFF, rows[i].exp);
        end
        // Manual reset while a bus cycle runs, with a slow vector memory
        slow <= 1'b1;
        bus_busy_i <= 1'b1;
        nmi_pin_i <= 1'b0;
        chip_init_pin_n_i <= 1'b0;
        repeat (8) @(posedge clk_i);
        chk({31'h0, periph_reset_o}, 32'h0);
        bus_busy_i <= 1'b0;
        repeat (16) @(posedge clk_i);
        chk({29'h0, periph_reset_o, kept_reset_o, refresh_en_o}, 32'h5);
        chk({31'h0, fetch_o.req}, 32'h0);
        wb(1'b0, rvf_pkg::RVF_CTRL_OFS, 32'h0);
        chk(rdat, 32'h0);
        chip_init_pin_n_i <= 1'b1;
        wait_run();
        chk(pc_o, 32'hA500_0008);
        chk(sp_o, 32'hA500_000C);
        chk(vector_table_base_o, 32'h0);
        // Power-on reset, with an exception request arriving inside it
        nmi_pin_i <= 1'b1;
        chip_init_pin_n_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        exc_req_i <= 1'b1;
        @(posedge clk_i);
        exc_req_i <= 1'b0;
        repeat (16) @(posedge clk_i);
        chk({30'h0, kept_reset_o, refresh_en_o}, 32'h2);
        chip_init_pin_n_i <= 1'b1;
        wait_run();
        chk(pc_o, 32'hA500_0000);
        wb(1'b0, rvf_pkg::RVF_STAT_OFS, 32'h0);
        chk(rdat, 32'h0000_0004);
        pin_reset(1'b1, 8);
        wb(1'b0, rvf_pkg::RVF_STAT_OFS, 32'h0);
        chk(rdat, 32'h0000_0005);
        wb(1'b1, rvf_pkg::RVF_STAT_OFS, 32'h1);
        wb(1'b0, rvf_pkg::RVF_STAT_OFS, 32'h0);
        chk(rdat, 32'h0000_0004);
        // A hold of exactly the minimum length must not be flagged short
        pin_reset(1'b1, 20);
        wb(1'b0, rvf_pkg::RVF_STAT_OFS, 32'h0);
        chk(rdat, 32'h0000_0004);
        test_done();
    end
endmodule
